// file: rtl/gp_ports_top.sv
// Contract
// RULE1 - data registers readable and writable any time; first and wide port data are unmapped outside single-chip
// RULE2 - per-pin direction, except analog and control 1:0
// RULE3 - all pins are inputs after reset
// RULE4 - expanded modes: first port carries address/data
// RULE5 - first port data unmapped in expanded/peripheral
// RULE6 - first two direction registers unmapped outside single-chip
// RULE7 - direction one drives output, zero makes input
// RULE8 - first port direction resets to zero
// RULE9 - pull-up bit pulls up all input pins
// RULE10 - pull-up inactive while port serves bus
// RULE11 - reduced-drive bit lowers port output strength
// RULE12 - reduced-drive register writable once per reset
// RULE13 - reduced-drive register unmapped in peripheral mode
// RULE14 - pulse modulator drives four low pulse pins
// RULE15 - timer pins general purpose unless timer-enabled
// RULE16 - data read: pin for inputs, latch for outputs
`default_nettype none
`include "gp_ports_regs.svh"
module gp_ports_top import gp_pkg::*; #(
  parameter int AW = 12,
  parameter int DLC_W = 7
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [AW-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [AW-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [1:0] mode_in,
  input wire logic [15:0] ext_bus_in,
  input wire logic ext_bus_oe_in,
  input wire logic [3:0] pwm_enable_in,
  input wire logic [3:0] pwm_level_in,
  input wire logic [7:0] timer_enable_in,
  input wire logic [7:0] timer_level_in,
  input wire logic [7:0] timer_drive_in,
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe_out,
  output logic [7:0] first_port_pullup_out,
  output logic first_port_low_drive_out,
  input wire logic [7:0] wide_port_b_pins_in,
  output logic [7:0] wide_port_b_pins_out,
  output logic [7:0] wide_port_b_pins_oe_out,
  output logic [7:0] wide_port_b_pullup_out,
  output logic wide_port_b_low_drive_out,
  input wire logic [7:0] control_port_pins_in,
  output logic [7:0] control_port_pins_out,
  output logic [7:0] control_port_pins_oe_out,
  output logic [7:0] control_port_pullup_out,
  output logic control_port_low_drive_out,
  input wire logic [7:0] pulse_port_pins_in,
  output logic [7:0] pulse_port_pins_out,
  output logic [7:0] pulse_port_pins_oe_out,
  input wire logic [7:0] timer_port_pins_in,
  output logic [7:0] timer_port_pins_out,
  output logic [7:0] timer_port_pins_oe_out,
  input wire logic [DLC_W-1:0] link_port_pins_in,
  output logic [DLC_W-1:0] link_port_pins_out,
  output logic [DLC_W-1:0] link_port_pins_oe_out,
  input wire logic [7:0] analog_port_pins_in
);
  gp_reg_if rif ();
  mode_e mode;
  logic bus_mode;
  byte_t pullup_control_register, next_pullup_ctrl;
  byte_t reduced_drive_register, next_low_drive;
  logic low_drive_locked, next_locked;
  byte_t a_rd, b_rd, e_rd, p_rd, t_rd, a_dir, e_dir, p_dir, t_dir;
  logic [DLC_W-1:0] dlc_rd, dlc_dir;
  logic [8:0] wr_sel;
  byte_t rd_mux;

  function automatic mode_e decode_mode(input logic [1:0] m);
    case (m)
      2'b00: return MODE_SINGLE;
      2'b01: return MODE_EXPANDED;
      default: return MODE_PERIPH;
    endcase
  endfunction

  function automatic logic reg_mapped(input byte_t i, input mode_e m);
    case (i)
      `GP_IDX_A_DATA, `GP_IDX_B_DATA,
      `GP_IDX_A_DIR, `GP_IDX_B_DIR: return m == MODE_SINGLE; // RULE5 RULE6
      `GP_IDX_LOW_DRIVE: return m != MODE_PERIPH; // RULE13
      `GP_IDX_E_DATA, `GP_IDX_E_DIR, `GP_IDX_PULLUP_CTRL,
      `GP_IDX_P_DATA, `GP_IDX_P_DIR, `GP_IDX_AD_DATA,
      `GP_IDX_T_DATA, `GP_IDX_T_DIR,
      `GP_IDX_DLC_DATA, `GP_IDX_DLC_DIR: return 1'b1; // RULE1
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic we(input byte_t i, input logic [8:0] s);
    return s[8] && (s[7:0] == i);
  endfunction

  assign mode = decode_mode(mode_in);
  assign bus_mode = (mode != MODE_SINGLE);
  assign rif.err = !reg_mapped(rif.idx, mode);
  assign rif.rdata = rd_mux;
  assign wr_sel = {rif.wr && reg_mapped(rif.idx, mode), rif.idx};

  gp_bus_slave #(.AW(AW)) u_slave (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
    .awready_out(awready_out), .wdata_in(wdata_in),
    .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
    .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
    .araddr_in(araddr_in), .arvalid_in(arvalid_in),
    .arready_out(arready_out), .rdata_out(rdata_out),
    .rresp_out(rresp_out), .rvalid_out(rvalid_out),
    .rready_in(rready_in), .rif(rif)
  );

  always_comb begin
    next_pullup_ctrl = pullup_control_register;
    next_low_drive = reduced_drive_register;
    next_locked = low_drive_locked;
    if (we(`GP_IDX_PULLUP_CTRL, wr_sel)) begin
      next_pullup_ctrl = rif.wdata & `GP_MASK_CTRL;
    end
    if (we(`GP_IDX_LOW_DRIVE, wr_sel)) begin
      next_locked = 1'b1; // RULE12
      if (!low_drive_locked) begin
        next_low_drive = rif.wdata & `GP_MASK_CTRL; // RULE12
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pullup_control_register <= `GP_RST_BYTE;
      reduced_drive_register <= `GP_RST_BYTE;
      low_drive_locked <= 1'b0;
    end else begin
      pullup_control_register <= next_pullup_ctrl;
      reduced_drive_register <= next_low_drive;
      low_drive_locked <= next_locked;
    end
  end

  always_comb begin
    case (rif.idx)
      `GP_IDX_A_DATA: rd_mux = a_rd;
      `GP_IDX_B_DATA: rd_mux = b_rd;
      `GP_IDX_A_DIR: rd_mux = a_dir;
      `GP_IDX_B_DIR: rd_mux = wide_port_b_pins_oe_out;
      `GP_IDX_E_DATA: rd_mux = e_rd;
      `GP_IDX_E_DIR: rd_mux = e_dir;
      `GP_IDX_PULLUP_CTRL: rd_mux = pullup_control_register;
      `GP_IDX_LOW_DRIVE: rd_mux = reduced_drive_register;
      `GP_IDX_P_DATA: rd_mux = p_rd;
      `GP_IDX_P_DIR: rd_mux = p_dir;
      `GP_IDX_AD_DATA: rd_mux = analog_port_pins_in; // RULE2
      `GP_IDX_T_DATA: rd_mux = t_rd;
      `GP_IDX_T_DIR: rd_mux = t_dir;
      `GP_IDX_DLC_DATA: rd_mux = {{(8 - DLC_W){1'b0}}, dlc_rd};
      `GP_IDX_DLC_DIR: rd_mux = {{(8 - DLC_W){1'b0}}, dlc_dir};
      default: rd_mux = `GP_RST_BYTE;
    endcase
  end

  // first port and wide port carry the external bus outside single-chip
  gp_port_bank #(.W(8)) u_port_a (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_A_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_A_DIR, wr_sel)),
    .wdata_in(rif.wdata), .alt_sel_in({8{bus_mode}}), // RULE4
    .alt_out_in(ext_bus_in[7:0]), .alt_oe_in({8{ext_bus_oe_in}}),
    .pull_en_in(pullup_control_register[`GP_BIT_A] && !bus_mode), // RULE10
    .low_en_in(reduced_drive_register[`GP_BIT_A]), // RULE11
    .pin_in(first_port_pins_in), .pin_out(first_port_pins_out),
    .pin_oe_out(first_port_pins_oe_out),
    .pull_out(first_port_pullup_out), .low_out(first_port_low_drive_out),
    .rd_data_out(a_rd), .dir_out(a_dir)
  );

  gp_port_bank #(.W(8)) u_port_b (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_B_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_B_DIR, wr_sel)),
    .wdata_in(rif.wdata), .alt_sel_in({8{bus_mode}}),
    .alt_out_in(ext_bus_in[15:8]), .alt_oe_in({8{ext_bus_oe_in}}),
    .pull_en_in(pullup_control_register[`GP_BIT_B] && !bus_mode),
    .low_en_in(reduced_drive_register[`GP_BIT_B]),
    .pin_in(wide_port_b_pins_in), .pin_out(wide_port_b_pins_out),
    .pin_oe_out(wide_port_b_pins_oe_out),
    .pull_out(wide_port_b_pullup_out), .low_out(wide_port_b_low_drive_out),
    .rd_data_out(b_rd), .dir_out()
  );

  gp_port_bank #(.W(8), .FIXED_IN(`GP_E_FIXED_IN)) u_port_e (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_E_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_E_DIR, wr_sel)),
    .wdata_in(rif.wdata), .alt_sel_in(8'h00), .alt_out_in(8'h00),
    .alt_oe_in(8'h00), .pull_en_in(pullup_control_register[`GP_BIT_E]),
    .low_en_in(reduced_drive_register[`GP_BIT_E]),
    .pin_in(control_port_pins_in), .pin_out(control_port_pins_out),
    .pin_oe_out(control_port_pins_oe_out),
    .pull_out(control_port_pullup_out),
    .low_out(control_port_low_drive_out), .rd_data_out(e_rd),
    .dir_out(e_dir)
  );

  gp_port_bank #(.W(8)) u_port_p (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_P_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_P_DIR, wr_sel)),
    .wdata_in(rif.wdata), .alt_sel_in({4'h0, pwm_enable_in}), // RULE14
    .alt_out_in({4'h0, pwm_level_in}), .alt_oe_in({4'h0, pwm_enable_in}),
    .pull_en_in(1'b0), .low_en_in(1'b0),
    .pin_in(pulse_port_pins_in), .pin_out(pulse_port_pins_out),
    .pin_oe_out(pulse_port_pins_oe_out), .pull_out(), .low_out(),
    .rd_data_out(p_rd), .dir_out(p_dir)
  );

  gp_port_bank #(.W(8)) u_port_t (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_T_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_T_DIR, wr_sel)),
    .wdata_in(rif.wdata), .alt_sel_in(timer_enable_in), // RULE15
    .alt_out_in(timer_level_in), .alt_oe_in(timer_drive_in),
    .pull_en_in(1'b0), .low_en_in(1'b0),
    .pin_in(timer_port_pins_in), .pin_out(timer_port_pins_out),
    .pin_oe_out(timer_port_pins_oe_out), .pull_out(), .low_out(),
    .rd_data_out(t_rd), .dir_out(t_dir)
  );

  gp_port_bank #(.W(DLC_W)) u_port_dlc (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .data_we_in(we(`GP_IDX_DLC_DATA, wr_sel)),
    .dir_we_in(we(`GP_IDX_DLC_DIR, wr_sel)),
    .wdata_in(rif.wdata[DLC_W-1:0]), .alt_sel_in('0), .alt_out_in('0),
    .alt_oe_in('0), .pull_en_in(1'b0), .low_en_in(1'b0),
    .pin_in(link_port_pins_in), .pin_out(link_port_pins_out),
    .pin_oe_out(link_port_pins_oe_out), .pull_out(), .low_out(),
    .rd_data_out(dlc_rd), .dir_out(dlc_dir)
  );

  // checks
  property p_dir_reset;
    @(posedge clk_in) $rose(nrst_in) |->
      a_dir == 8'h00 && first_port_pins_oe_out == 8'h00;
  endproperty
  a_dir_reset: assert property (p_dir_reset) // RULE8
    else $error("first port not input after reset");

  property p_dir_write;
    @(posedge clk_in) disable iff (!nrst_in)
    (we(`GP_IDX_A_DIR, wr_sel) && mode == MODE_SINGLE) ##1
    (mode == MODE_SINGLE) |-> first_port_pins_oe_out == $past(rif.wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) // RULE7
    else $error("direction write did not set pin drive");

  property p_unmapped;
    @(posedge clk_in) disable iff (!nrst_in)
    (rif.rd && mode != MODE_SINGLE &&
     (rif.idx == `GP_IDX_A_DATA || rif.idx == `GP_IDX_A_DIR))
      |=> rvalid_out && rresp_out == `GP_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE5
    else $error("first port register visible in bus mode");

  property p_write_once;
    @(posedge clk_in) disable iff (!nrst_in)
    (low_drive_locked && rif.wr) |=> $stable(reduced_drive_register);
  endproperty
  a_write_once: assert property (p_write_once) // RULE12
    else $error("reduced drive register changed twice");

  property p_low_drive_periph;
    @(posedge clk_in) disable iff (!nrst_in)
    (rif.rd && rif.idx == `GP_IDX_LOW_DRIVE && mode == MODE_PERIPH)
      |=> rvalid_out && rresp_out == `GP_RESP_SLVERR;
  endproperty
  a_low_drive_periph: assert property (p_low_drive_periph) // RULE13
    else $error("reduced drive register mapped in peripheral mode");

  property p_pull_bus;
    @(posedge clk_in) disable iff (!nrst_in)
    bus_mode |=> first_port_pullup_out == 8'h00;
  endproperty
  a_pull_bus: assert property (p_pull_bus) // RULE10
    else $error("pull-ups active in bus mode");

  property p_pwm;
    @(posedge clk_in) disable iff (!nrst_in)
    pwm_enable_in[0] |=> pulse_port_pins_oe_out[0] &&
      pulse_port_pins_out[0] == $past(pwm_level_in[0]);
  endproperty
  a_pwm: assert property (p_pwm) // RULE14
    else $error("pulse pin not driven by modulator");

  property p_e_input_only;
    @(posedge clk_in) disable iff (!nrst_in)
    control_port_pins_oe_out[1:0] == 2'b00;
  endproperty
  a_e_input_only: assert property (p_e_input_only) // RULE2
    else $error("input-only control pin driven");

  property p_read_pin;
    @(posedge clk_in) disable iff (!nrst_in)
    (rif.rd && rif.idx == `GP_IDX_A_DATA && mode == MODE_SINGLE &&
     a_dir == 8'h00) |=> rdata_out[7:0] == $past(first_port_pins_in);
  endproperty
  a_read_pin: assert property (p_read_pin) // RULE16
    else $error("input pin level not returned");

  c_write: cover property (@(posedge clk_in) bvalid_out && bready_in);
  c_read: cover property (@(posedge clk_in) rvalid_out && rready_in);
  c_lock: cover property (@(posedge clk_in) low_drive_locked && rif.wr);
  c_bus: cover property (@(posedge clk_in) bus_mode && rif.err);
endmodule
`default_nettype wire

// file: pkg/gp_ports_regs.svh
`ifndef GP_PORTS_REGS_SVH
`define GP_PORTS_REGS_SVH
// register indices; byte address is four times the index
`define GP_IDX_A_DATA 8'h00
`define GP_IDX_B_DATA 8'h01
`define GP_IDX_A_DIR 8'h02
`define GP_IDX_B_DIR 8'h03
`define GP_IDX_E_DATA 8'h08
`define GP_IDX_E_DIR 8'h09
`define GP_IDX_PULLUP_CTRL 8'h0c
`define GP_IDX_LOW_DRIVE 8'h0d
`define GP_IDX_P_DATA 8'h56
`define GP_IDX_P_DIR 8'h57
`define GP_IDX_AD_DATA 8'h6f
`define GP_IDX_T_DATA 8'hae
`define GP_IDX_T_DIR 8'haf
`define GP_IDX_DLC_DATA 8'hfe
`define GP_IDX_DLC_DIR 8'hff
// field positions in pullup_control_register and reduced_drive_register
`define GP_BIT_A 0
`define GP_BIT_B 1
`define GP_BIT_E 4
`define GP_MASK_CTRL 8'h13
// reset values and fixed masks
`define GP_RST_BYTE 8'h00
`define GP_E_FIXED_IN 8'h03
// bus responses and address split
`define GP_RESP_OKAY 2'b00
`define GP_RESP_SLVERR 2'b10
`define GP_IDX_LSB 2
`define GP_IDX_MSB 9
`endif

// file: pkg/gp_pkg.sv
`default_nettype none
package gp_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b001,
    MODE_EXPANDED = 3'b010,
    MODE_PERIPH = 3'b100
  } mode_e;
  typedef enum logic [2:0] {
    AX_IDLE = 3'b001,
    AX_WRESP = 3'b010,
    AX_RRESP = 3'b100
  } axi_state_e;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// file: pkg/gp_reg_if.sv
`default_nettype none
interface gp_reg_if;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic err;
  modport slave_side (output wr, rd, idx, wdata, input rdata, err);
  modport core_side (input wr, rd, idx, wdata, output rdata, err);
endinterface
`default_nettype wire

// file: rtl/gp_port_bank.sv
`default_nettype none
module gp_port_bank import gp_pkg::*; #(
  parameter int W = 8,
  parameter logic [W-1:0] FIXED_IN = '0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic data_we_in,
  input wire logic dir_we_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic [W-1:0] alt_sel_in,
  input wire logic [W-1:0] alt_out_in,
  input wire logic [W-1:0] alt_oe_in,
  input wire logic pull_en_in,
  input wire logic low_en_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out,
  output logic [W-1:0] pull_out,
  output logic low_out,
  output logic [W-1:0] rd_data_out,
  output logic [W-1:0] dir_out
);
  logic [W-1:0] data;
  logic [W-1:0] dir;
  logic [W-1:0] next_data;
  logic [W-1:0] next_dir;
  logic [W-1:0] next_oe;
  logic [W-1:0] next_out;
  logic [W-1:0] next_pull;

  always_comb begin
    next_data = data_we_in ? wdata_in : data; // RULE1
    next_dir = (dir_we_in ? wdata_in : dir) & ~FIXED_IN; // RULE2 RULE7
    next_oe = (alt_sel_in & alt_oe_in) | (~alt_sel_in & next_dir);
    next_out = (alt_sel_in & alt_out_in) | (~alt_sel_in & next_data);
    next_pull = pull_en_in ? ~next_oe : '0; // RULE9
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      data <= '0;
      dir <= '0; // RULE3 RULE8
      pin_out <= '0;
      pin_oe_out <= '0;
      pull_out <= '0;
      low_out <= 1'b0;
    end else begin
      data <= next_data;
      dir <= next_dir;
      pin_out <= next_out;
      pin_oe_out <= next_oe;
      pull_out <= next_pull;
      low_out <= low_en_in; // RULE11
    end
  end

  // pin level for inputs, latch for outputs
  assign rd_data_out = (dir & data) | (~dir & pin_in); // RULE16
  assign dir_out = dir;
endmodule
`default_nettype wire

// file: rtl/gp_bus_slave.sv
`default_nettype none
`include "gp_ports_regs.svh"
module gp_bus_slave import gp_pkg::*; #(
  parameter int AW = 12
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [AW-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [AW-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  gp_reg_if.slave_side rif
);
  axi_state_e state, next_state;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [AW-1:0] waddr, next_waddr;
  byte_t wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, rd_fire;

  function automatic logic in_range(input logic [AW-1:0] a);
    return (a >> (`GP_IDX_MSB + 1)) == '0;
  endfunction

  assign wr_fire = (state == AX_IDLE) && aw_held && w_held;
  assign rd_fire = arvalid_in && arready_out;
  assign rif.wr = wr_fire && in_range(waddr) && wlane;
  assign rif.rd = rd_fire && in_range(araddr_in);
  assign rif.idx = wr_fire ? waddr[`GP_IDX_MSB:`GP_IDX_LSB]
                           : araddr_in[`GP_IDX_MSB:`GP_IDX_LSB];
  assign rif.wdata = wbyte;

  always_comb begin
    next_state = state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = bvalid_out;
    next_bresp = bresp_out;
    next_rvalid = rvalid_out;
    next_rresp = rresp_out;
    next_rdata = rdata_out;
    if (awvalid_in && awready_out) begin
      next_aw_held = 1'b1;
      next_waddr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      next_w_held = 1'b1;
      next_wbyte = wdata_in[7:0];
      next_wlane = wstrb_in[0];
    end
    case (state)
      AX_IDLE: begin
        if (wr_fire) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = (in_range(waddr) && !rif.err) ? `GP_RESP_OKAY
                                                     : `GP_RESP_SLVERR;
          next_state = AX_WRESP;
        end else if (rd_fire) begin
          next_rvalid = 1'b1;
          if (in_range(araddr_in) && !rif.err) begin
            next_rdata = {24'h00_0000, rif.rdata};
            next_rresp = `GP_RESP_OKAY;
          end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = `GP_RESP_SLVERR;
          end
          next_state = AX_RRESP;
        end
      end
      AX_WRESP: begin
        if (bready_in) begin
          next_bvalid = 1'b0;
          next_state = AX_IDLE;
        end
      end
      AX_RRESP: begin
        if (rready_in) begin
          next_rvalid = 1'b0;
          next_state = AX_IDLE;
        end
      end
      default: next_state = AX_IDLE;
    endcase
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_arready = (next_state == AX_IDLE) && !(next_aw_held && next_w_held);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= AX_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wbyte <= `GP_RST_BYTE;
      wlane <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      arready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= `GP_RESP_OKAY;
      rvalid_out <= 1'b0;
      rresp_out <= `GP_RESP_OKAY;
      rdata_out <= 32'h0000_0000;
    end else begin
      state <= next_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      awready_out <= next_awready;
      wready_out <= next_wready;
      arready_out <= next_arready;
      bvalid_out <= next_bvalid;
      bresp_out <= next_bresp;
      rvalid_out <= next_rvalid;
      rresp_out <= next_rresp;
      rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// file: test/pin_board.sv
`default_nettype none
module pin_board #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic [W-1:0] out_in,
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] pull_in,
  input wire logic [W-1:0] ext_in,
  input wire logic [W-1:0] ext_en_in,
  output logic [W-1:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] last = '0;
  // a floating line without pull-up flips every cycle
  always @(posedge clk_in) begin
    last <= pin_out;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_in[i]) pin_out[i] = out_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_in[i];
      else if (pull_in[i]) pin_out[i] = 1'b1;
      else pin_out[i] = ~last[i];
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, ebo;
  logic [11:0] aw, ar;
  logic [31:0] wd, rd, d;
  logic [1:0] br, rs, mode, r;
  logic [15:0] eb;
  logic [3:0] pwe, pwl;
  logic [7:0] te, tl, tdr;
  logic [54:0] pins, outs, oes, pulls, ext, exe;
  logic [2:0] ld;
  int err_count, n_compared, cyc;
  assign pulls[54:24] = '0;
  assign outs[54:47] = '0;
  assign oes[54:47] = '0;
  gp_ports_top i_gp_ports_top (.clk_in(clk), .nrst_in(nrst),
    .awaddr_in(aw), .awvalid_in(awv), .awready_out(awr), .wdata_in(wd),
    .wstrb_in(4'h1), .wvalid_in(wv), .wready_out(wrd), .bresp_out(br),
    .bvalid_out(bv), .bready_in(bry), .araddr_in(ar), .arvalid_in(arv),
    .arready_out(arr), .rdata_out(rd), .rresp_out(rs), .rvalid_out(rv),
    .rready_in(rry), .mode_in(mode), .ext_bus_in(eb), .ext_bus_oe_in(ebo),
    .pwm_enable_in(pwe), .pwm_level_in(pwl), .timer_enable_in(te),
    .timer_level_in(tl), .timer_drive_in(tdr),
    .first_port_pins_in(pins[7:0]), .first_port_pins_out(outs[7:0]),
    .first_port_pins_oe_out(oes[7:0]), .first_port_pullup_out(pulls[7:0]),
    .first_port_low_drive_out(ld[0]), .wide_port_b_pins_in(pins[15:8]),
    .wide_port_b_pins_out(outs[15:8]), .wide_port_b_pins_oe_out(oes[15:8]),
    .wide_port_b_pullup_out(pulls[15:8]), .wide_port_b_low_drive_out(ld[1]),
    .control_port_pins_in(pins[23:16]), .control_port_pins_out(outs[23:16]),
    .control_port_pins_oe_out(oes[23:16]),
    .control_port_pullup_out(pulls[23:16]),
    .control_port_low_drive_out(ld[2]), .pulse_port_pins_in(pins[31:24]),
    .pulse_port_pins_out(outs[31:24]), .pulse_port_pins_oe_out(oes[31:24]),
    .timer_port_pins_in(pins[39:32]), .timer_port_pins_out(outs[39:32]),
    .timer_port_pins_oe_out(oes[39:32]), .link_port_pins_in(pins[46:40]),
    .link_port_pins_out(outs[46:40]), .link_port_pins_oe_out(oes[46:40]),
    .analog_port_pins_in(pins[54:47]));
  pin_board #(.W(55)) i_pin_board (.clk_in(clk), .out_in(outs),
    .oe_in(oes), .pull_in(pulls), .ext_in(ext), .ext_en_in(exe),
    .pin_out(pins));
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ck(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    aw <= {2'h0, i, 2'h0};
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e,
    input logic [1:0] er);
    ar <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    rry <= 1'b0;
    ck(d, e);
    ck(rs, er);
    @(posedge clk);
  endtask
  task automatic t_reset;
    ck(oes, '0);
    rc(8'h02, 32'h0, 2'h0);
    rc(8'h09, 32'h0, 2'h0);
  endtask
  task automatic t_dir;
    wr(8'h00, 8'ha5);
    wr(8'h02, 8'h0f);
    ck(oes[7:0], 8'h0f);
    ck(outs[3:0], 4'h5);
    rc(8'h00, 32'h35, 2'h0);
    rc(8'h02, 32'h0f, 2'h0);
  endtask
  task automatic t_ctrl;
    wr(8'h09, 8'hff);
    ck(oes[23:16], 8'hfc);
    rc(8'h09, 32'hfc, 2'h0);
    rc(8'h6f, 32'h96, 2'h0);
    wr(8'h0c, 8'h13);
    ck(pulls[23:0], 24'h03_fff0);
    wr(8'h08, 8'ha5);
    ck(outs[23:16], 8'ha5);
    rc(8'h08, 32'ha7, 2'h0);
    wr(8'h02, 8'h00);
    ck(oes[7:0], 8'h00);
    rc(8'h00, 32'h3f, 2'h0);
    wr(8'hfe, 8'h2b);
    wr(8'hff, 8'h7f);
    ck({oes[46:40], outs[46:40]}, 14'h3fab);
    rc(8'hfe, 32'h2b, 2'h0);
    rc(8'hff, 32'h7f, 2'h0);
  endtask
  task automatic t_drive;
    wr(8'h0d, 8'h01);
    ck(ld, 3'h1);
    wr(8'h0d, 8'h12);
    ck(r, 2'h0);
    rc(8'h0d, 32'h01, 2'h0);
    ck(ld, 3'h1);
  endtask
  task automatic t_alt;
    pwe <= 4'h5;
    pwl <= 4'h1;
    te <= 8'h0f;
    tl <= 8'haa;
    tdr <= 8'h03;
    wr(8'haf, 8'hf0);
    wr(8'hae, 8'hff);
    ck(oes[27:24], 4'h5);
    ck({outs[26], outs[24]}, 2'h1);
    ck({oes[39:32], outs[39:32]}, 16'hf3fa);
    pwe <= 4'h0;
    repeat (2) @(posedge clk);
    ck(oes[27:24], 4'h0);
  endtask
  task automatic t_mode;
    mode <= 2'h1;
    repeat (2) @(posedge clk);
    ck({outs[15:0], oes[15:0]}, 32'hc35a_ffff);
    ck(pulls[15:0], 16'h0);
    rc(8'h00, 32'h0, 2'h2);
    rc(8'h02, 32'h0, 2'h2);
    rc(8'h03, 32'h0, 2'h2);
    rc(8'h0d, 32'h01, 2'h0);
    mode <= 2'h2;
    repeat (2) @(posedge clk);
    rc(8'h0d, 32'h0, 2'h2);
    rc(8'h01, 32'h0, 2'h2);
    rc(8'h20, 32'h0, 2'h2);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {nrst, awv, wv, bry, arv, rry, mode, pwe, pwl, te, tl, tdr} = '0;
    {aw, ar, wd, cyc, err_count, n_compared} = '0;
    eb = 16'hc35a;
    ebo = 1'b1;
    ext = {8'h96, 39'h0, 8'h3c};
    exe = {8'hff, 39'h0, 8'hf0};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_dir();
    t_ctrl();
    t_drive();
    t_alt();
    t_mode();
    end_sim();
  end
endmodule
`default_nettype wire
